// ==== hdl/pafs_defs.vh ====
// What this block does
// - the pin shared by capture input a and the count input has no selector, both see it while its mode bit is set.
// - port 5 pin 0 joins its alternate functions when its mode bit is 1, ignoring latch and direction bits.
// - the valid edge of capture input a comes from a two-bit field of the timer-3 edge select register.
// - the valid edge of the count input comes from a separate two-bit field of that register.
// - port 5 pin 1 is capture input b when its mode bit is 1, its edge chosen by a third two-bit field.
// - port 5 pin 2 drives the timer-3 output when its mode bit is 1, whatever its latch and direction bits.
// - port 7 pins 0 to 7 are analog inputs 0 to 7 with no direction or mode bits, latch bits have no effect.
// - low address port pins 0 to 15 output address bits 0 to 15 when their mode bits are 1.
// - high address port pins 0 to 6 output address bits 16 to 22 when their mode bits are 1.
`ifndef PAFS_DEFS_VH
`define PAFS_DEFS_VH
`define PAFS_ADDR_P5_LATCH 12'h000
`define PAFS_ADDR_P5_DIR 12'h004
`define PAFS_ADDR_P5_MODE 12'h008
`define PAFS_ADDR_P5_IN 12'h00c
`define PAFS_ADDR_P7_IN 12'h010
`define PAFS_ADDR_AL_LATCH 12'h014
`define PAFS_ADDR_AL_DIR 12'h018
`define PAFS_ADDR_AL_MODE 12'h01c
`define PAFS_ADDR_AL_IN 12'h020
`define PAFS_ADDR_AH_LATCH 12'h024
`define PAFS_ADDR_AH_DIR 12'h028
`define PAFS_ADDR_AH_MODE 12'h02c
`define PAFS_ADDR_AH_IN 12'h030
`define PAFS_ADDR_EDGE_SEL 12'h034
`define PAFS_ADDR_P7_LATCH 12'h038
`define PAFS_EDGE_CAPA_LO 0
`define PAFS_EDGE_CAPB_LO 2
`define PAFS_EDGE_CNT_LO 4
`define PAFS_EDGE_FALL 2'b00
`define PAFS_EDGE_RISE 2'b01
`define PAFS_EDGE_BOTH 2'b11
`define PAFS_DIR_RESET 16'hffff
`define PAFS_ZERO_RESET 16'h0000
`define PAFS_P5_DIR_RESET 3'h7
`define PAFS_AH_DIR_RESET 7'h7f
`endif

// ==== hdl/pafs_edge.v ====
`timescale 1ns/100ps
`include "pafs_defs.vh"
// valid-edge detector on a synchronised input, gated by its mode bit
module pafs_edge (
  input wire clk,
  input wire srst,
  input wire en,
  input wire din,
  input wire [1:0] sel,
  output reg pulse
);
  reg prev_q;
  wire rise;
  wire fall;
  assign rise = din & ~prev_q;
  assign fall = ~din & prev_q;
  always @(posedge clk) begin
    if (srst) begin
      prev_q <= 1'b0;
      pulse <= 1'b0;
    end else begin
      prev_q <= din;
      // 2'b10 means no edge valid, the input is off
      if (!en) begin
        pulse <= 1'b0;
      end else if (sel == `PAFS_EDGE_FALL) begin
        pulse <= fall;
      end else if (sel == `PAFS_EDGE_RISE) begin
        pulse <= rise;
      end else if (sel == `PAFS_EDGE_BOTH) begin
        pulse <= rise | fall;
      end else begin
        pulse <= 1'b0;
      end
    end
  end
endmodule // pafs_edge

// ==== hdl/pafs_sync.v ====
`timescale 1ns/100ps
// two-flop synchroniser for a bus of pin inputs
module pafs_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule // pafs_sync

// ==== hdl/pafs_top.v ====
`timescale 1ns/100ps
`include "pafs_defs.vh"
module pafs_top (
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] p5_pin_in,
  output reg [2:0] p5_pin_out,
  output reg [2:0] p5_pin_oe,
  input wire [7:0] p7_pin_in,
  output wire [7:0] p7_analog_sel,
  input wire [15:0] al_pin_in,
  output reg [15:0] al_pin_out,
  output reg [15:0] al_pin_oe,
  input wire [6:0] ah_pin_in,
  output reg [6:0] ah_pin_out,
  output reg [6:0] ah_pin_oe,
  input wire timer3_out,
  input wire [22:0] ext_addr,
  output wire timer3_capture_irq_a,
  output wire timer3_capture_irq_b,
  output wire timer3_count_in
);
  reg [2:0] p5_latch_q;
  reg [2:0] p5_dir_q;
  reg [2:0] p5_mode_q;
  reg [7:0] p7_latch_q;
  reg [15:0] al_latch_q;
  reg [15:0] al_dir_q;
  reg [15:0] al_mode_q;
  reg [6:0] ah_latch_q;
  reg [6:0] ah_dir_q;
  reg [6:0] ah_mode_q;
  reg [5:0] edge_sel_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg hit;
  wire [2:0] p5_s;
  wire [7:0] p7_s;
  wire [15:0] al_s;
  wire [6:0] ah_s;
  wire wr_en;
  wire rd_en;
  wire [2:0] p5_out_d;
  wire [2:0] p5_oe_d;
  wire [15:0] al_out_d;
  wire [15:0] al_oe_d;
  wire [6:0] ah_out_d;
  wire [6:0] ah_oe_d;
  genvar g;

  // pin inputs come from outside the clock domain
  pafs_sync #(.W(3)) u_sync_p5 (
    .clk(clk),
    .srst(srst),
    .d(p5_pin_in),
    .q(p5_s)
  );
  pafs_sync #(.W(8)) u_sync_p7 (
    .clk(clk),
    .srst(srst),
    .d(p7_pin_in),
    .q(p7_s)
  );
  pafs_sync #(.W(16)) u_sync_al (
    .clk(clk),
    .srst(srst),
    .d(al_pin_in),
    .q(al_s)
  );
  pafs_sync #(.W(7)) u_sync_ah (
    .clk(clk),
    .srst(srst),
    .d(ah_pin_in),
    .q(ah_s)
  );

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  function [31:0] pad16;
    input [15:0] v;
    begin
      pad16 = {16'h0000, v};
    end
  endfunction

  always @* begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    if (paddr == `PAFS_ADDR_P5_LATCH) begin
      rdata_d = pad16({13'h0000, p5_latch_q});
    end else if (paddr == `PAFS_ADDR_P5_DIR) begin
      rdata_d = pad16({13'h0000, p5_dir_q});
    end else if (paddr == `PAFS_ADDR_P5_MODE) begin
      rdata_d = pad16({13'h0000, p5_mode_q});
    end else if (paddr == `PAFS_ADDR_P5_IN) begin
      rdata_d = pad16({13'h0000, p5_s});
    end else if (paddr == `PAFS_ADDR_P7_IN) begin
      rdata_d = pad16({8'h00, p7_s});
    end else if (paddr == `PAFS_ADDR_P7_LATCH) begin
      rdata_d = pad16({8'h00, p7_latch_q});
    end else if (paddr == `PAFS_ADDR_AL_LATCH) begin
      rdata_d = pad16(al_latch_q);
    end else if (paddr == `PAFS_ADDR_AL_DIR) begin
      rdata_d = pad16(al_dir_q);
    end else if (paddr == `PAFS_ADDR_AL_MODE) begin
      rdata_d = pad16(al_mode_q);
    end else if (paddr == `PAFS_ADDR_AL_IN) begin
      rdata_d = pad16(al_s);
    end else if (paddr == `PAFS_ADDR_AH_LATCH) begin
      rdata_d = pad16({9'h000, ah_latch_q});
    end else if (paddr == `PAFS_ADDR_AH_DIR) begin
      rdata_d = pad16({9'h000, ah_dir_q});
    end else if (paddr == `PAFS_ADDR_AH_MODE) begin
      rdata_d = pad16({9'h000, ah_mode_q});
    end else if (paddr == `PAFS_ADDR_AH_IN) begin
      rdata_d = pad16({9'h000, ah_s});
    end else if (paddr == `PAFS_ADDR_EDGE_SEL) begin
      rdata_d = pad16({10'h000, edge_sel_q});
    end else begin
      hit = 1'b0;
    end
  end

  // unmapped addresses read zero and report an error in the access phase
  assign pslverr = psel & penable & ~hit;
  assign prdata = rdata_q;

  always @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      p5_latch_q <= 3'h0;
      p5_dir_q <= `PAFS_P5_DIR_RESET;
      p5_mode_q <= 3'h0;
      p7_latch_q <= 8'h00;
      al_latch_q <= `PAFS_ZERO_RESET;
      al_dir_q <= `PAFS_DIR_RESET;
      al_mode_q <= `PAFS_ZERO_RESET;
      ah_latch_q <= 7'h00;
      ah_dir_q <= `PAFS_AH_DIR_RESET;
      ah_mode_q <= 7'h00;
      edge_sel_q <= 6'h00;
    end else if (wr_en) begin
      if (paddr == `PAFS_ADDR_P5_LATCH) begin
        p5_latch_q <= pwdata[2:0];
      end else if (paddr == `PAFS_ADDR_P5_DIR) begin
        p5_dir_q <= pwdata[2:0];
      end else if (paddr == `PAFS_ADDR_P5_MODE) begin
        p5_mode_q <= pwdata[2:0];
      end else if (paddr == `PAFS_ADDR_P7_LATCH) begin
        p7_latch_q <= pwdata[7:0];
      end else if (paddr == `PAFS_ADDR_AL_LATCH) begin
        al_latch_q <= pwdata[15:0];
      end else if (paddr == `PAFS_ADDR_AL_DIR) begin
        al_dir_q <= pwdata[15:0];
      end else if (paddr == `PAFS_ADDR_AL_MODE) begin
        al_mode_q <= pwdata[15:0];
      end else if (paddr == `PAFS_ADDR_AH_LATCH) begin
        ah_latch_q <= pwdata[6:0];
      end else if (paddr == `PAFS_ADDR_AH_DIR) begin
        ah_dir_q <= pwdata[6:0];
      end else if (paddr == `PAFS_ADDR_AH_MODE) begin
        ah_mode_q <= pwdata[6:0];
      end else if (paddr == `PAFS_ADDR_EDGE_SEL) begin
        edge_sel_q <= pwdata[5:0];
      end
    end
  end

  // port 7 latch is kept for software only and never reaches a pin
  assign p7_analog_sel = 8'hff;

  // capture a and the count input share pin 0 with no selector
  pafs_edge u_edge_capa (
    .clk(clk),
    .srst(srst),
    .en(p5_mode_q[0]),
    .din(p5_s[0]),
    .sel(edge_sel_q[`PAFS_EDGE_CAPA_LO +: 2]),
    .pulse(timer3_capture_irq_a)
  );
  pafs_edge u_edge_cnt (
    .clk(clk),
    .srst(srst),
    .en(p5_mode_q[0]),
    .din(p5_s[0]),
    .sel(edge_sel_q[`PAFS_EDGE_CNT_LO +: 2]),
    .pulse(timer3_count_in)
  );
  pafs_edge u_edge_capb (
    .clk(clk),
    .srst(srst),
    .en(p5_mode_q[1]),
    .din(p5_s[1]),
    .sel(edge_sel_q[`PAFS_EDGE_CAPB_LO +: 2]),
    .pulse(timer3_capture_irq_b)
  );

  // next pin values, one bit slice per pin
  generate
    // input-only alternates: pin undriven in mode, else plain port
    for (g = 0; g < 2; g = g + 1) begin : g_p5_in
      assign p5_out_d[g] = p5_mode_q[g] ? 1'b0 : p5_latch_q[g];
      assign p5_oe_d[g] = ~p5_mode_q[g] & ~p5_dir_q[g];
    end
    for (g = 0; g < 16; g = g + 1) begin : g_al
      assign al_out_d[g] = al_mode_q[g] ? ext_addr[g] : al_latch_q[g];
      assign al_oe_d[g] = al_mode_q[g] | ~al_dir_q[g];
    end
    for (g = 0; g < 7; g = g + 1) begin : g_ah
      assign ah_out_d[g] = ah_mode_q[g] ? ext_addr[16 + g] : ah_latch_q[g];
      assign ah_oe_d[g] = ah_mode_q[g] | ~ah_dir_q[g];
    end
  endgenerate
  assign p5_out_d[2] = p5_mode_q[2] ? timer3_out : p5_latch_q[2];
  assign p5_oe_d[2] = p5_mode_q[2] | ~p5_dir_q[2];

  // outputs registered so pins change one cycle after a mode write
  always @(posedge clk) begin
    if (srst) begin
      p5_pin_out <= 3'h0;
      p5_pin_oe <= 3'h0;
      al_pin_out <= 16'h0000;
      al_pin_oe <= 16'h0000;
      ah_pin_out <= 7'h00;
      ah_pin_oe <= 7'h00;
    end else begin
      p5_pin_out <= p5_out_d;
      p5_pin_oe <= p5_oe_d;
      al_pin_out <= al_out_d;
      al_pin_oe <= al_oe_d;
      ah_pin_out <= ah_out_d;
      ah_pin_oe <= ah_oe_d;
    end
  end
endmodule // pafs_top

// ==== verification/pafs_periph.sv ====
`timescale 1ns/100ps
// timer and bus controller stand-in; converter trigger routing lies outside
module pafs_periph (
  input wire clk,
  input wire srst,
  input wire irq_a,
  input wire irq_b,
  input wire cnt_in,
  input wire mask_a,
  output reg t3_out,
  output reg [22:0] addr,
  output reg [7:0] n_a,
  output reg [7:0] n_b,
  output reg [7:0] n_t
);
  always @(posedge clk) begin
    if (srst) begin
      t3_out <= 1'b0;
      addr <= 23'h0;
      n_a <= 8'h0;
      n_b <= 8'h0;
      n_t <= 8'h0;
    end else begin
      // both move every cycle so a stale pin value never matches
      t3_out <= ~t3_out;
      addr <= addr + 23'h2b5e9d;
      if (irq_a && !mask_a) n_a <= n_a + 8'h1;
      if (cnt_in && mask_a) n_t <= n_t + 8'h1;
      if (irq_b) n_b <= n_b + 8'h1;
    end
  end
endmodule // pafs_periph

// ==== verification/pafs_top_properties.sv ====
`timescale 1ns/100ps
`include "pafs_defs.vh"
module pafs_checker (
  input wire clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [2:0] p5_pin_in,
  input wire [2:0] p5_pin_out,
  input wire [2:0] p5_pin_oe,
  input wire [7:0] p7_analog_sel,
  input wire [15:0] al_pin_out,
  input wire [15:0] al_pin_oe,
  input wire [6:0] ah_pin_out,
  input wire [6:0] ah_pin_oe,
  input wire timer3_out,
  input wire [22:0] ext_addr,
  input wire timer3_capture_irq_a,
  input wire timer3_capture_irq_b,
  input wire timer3_count_in
);
  // shadow copies of the mode and edge registers, taken from the bus
  reg [2:0] m5_q;
  reg [15:0] ml_q;
  reg [6:0] mh_q;
  reg [5:0] es_q;
  wire wr = psel & penable & pwrite & pready;
  always @(posedge clk) begin
    if (srst) begin
      m5_q <= 3'h0;
      ml_q <= 16'h0;
      mh_q <= 7'h0;
      es_q <= 6'h0;
    end else if (wr) begin
      if (paddr == `PAFS_ADDR_P5_MODE) m5_q <= pwdata[2:0];
      if (paddr == `PAFS_ADDR_AL_MODE) ml_q <= pwdata[15:0];
      if (paddr == `PAFS_ADDR_AH_MODE) mh_q <= pwdata[6:0];
      if (paddr == `PAFS_ADDR_EDGE_SEL) es_q <= pwdata[5:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  analog_sel_a: assert property (p7_analog_sel == 8'hff)
    else $error("analog select not all ones");
  t3_out_a: assert property (m5_q[2] |=> p5_pin_oe[2] && p5_pin_out[2] == $past(timer3_out))
    else $error("timer output not on pin");
  addr_lo_a: assert property (1 |=> (((al_pin_out ^ $past(ext_addr[15:0])) | ~al_pin_oe)
    & $past(ml_q)) == 16'h0) else $error("low address pins wrong");
  addr_hi_a: assert property (1 |=> (((ah_pin_out ^ $past(ext_addr[22:16])) | ~ah_pin_oe)
    & $past(mh_q)) == 7'h0) else $error("high address pins wrong");
  gate_off_a: assert property (!m5_q[0] [*4] |-> !timer3_capture_irq_a && !timer3_count_in)
    else $error("pulse with mode bit clear");
  cap_a_rise_a: assert property (m5_q[0] && es_q[1:0] == 2'b01 && $rose(p5_pin_in[0])
    |-> ##[1:4] timer3_capture_irq_a) else $error("capture a missed rise");
  cnt_fall_a: assert property (m5_q[0] && es_q[5:4] == 2'b00 && $fell(p5_pin_in[0])
    |-> ##[1:4] timer3_count_in) else $error("count input missed fall");
  cap_b_both_a: assert property (m5_q[1] && es_q[3:2] == 2'b11 && $changed(p5_pin_in[1])
    |-> ##[1:4] timer3_capture_irq_b) else $error("capture b missed edge");
  cap_b_pulse_a: assert property (timer3_capture_irq_b |=> !timer3_capture_irq_b)
    else $error("capture b pulse too long");
  p5_in_off_a: assert property (m5_q[0] |=> !p5_pin_oe[0])
    else $error("input alternate pin driven");
  cover property (timer3_capture_irq_a);
  cover property (timer3_count_in);
  cover property (timer3_capture_irq_b);
endmodule // pafs_checker

// ==== verification/pafs_top_tb.sv ====
`timescale 1ns/100ps
`include "pafs_defs.vh"
module pafs_top_tb;
  reg clk, srst, psel, penable, pwrite, mask_a;
  reg [11:0] paddr;
  reg [31:0] pwdata, rv, pa;
  reg [2:0] p5_pin_in;
  reg [7:0] p7_pin_in;
  reg er, pt;
  wire [31:0] prdata;
  wire pready, pslverr, timer3_out, timer3_capture_irq_a, timer3_capture_irq_b, timer3_count_in;
  wire [2:0] p5_pin_out, p5_pin_oe;
  wire [7:0] p7_analog_sel, n_a, n_b, n_t;
  wire [15:0] al_pin_out, al_pin_oe;
  wire [15:0] al_pin_in = 16'h0;
  wire [6:0] ah_pin_out, ah_pin_oe;
  wire [6:0] ah_pin_in = 7'h0;
  wire [22:0] ext_addr;
  integer fails, checks, cyc, i;
  pafs_top i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p5_pin_in(p5_pin_in), .p5_pin_out(p5_pin_out), .p5_pin_oe(p5_pin_oe),
    .p7_pin_in(p7_pin_in), .p7_analog_sel(p7_analog_sel), .al_pin_in(al_pin_in),
    .al_pin_out(al_pin_out), .al_pin_oe(al_pin_oe), .ah_pin_in(ah_pin_in),
    .ah_pin_out(ah_pin_out), .ah_pin_oe(ah_pin_oe), .timer3_out(timer3_out),
    .ext_addr(ext_addr), .timer3_capture_irq_a(timer3_capture_irq_a),
    .timer3_capture_irq_b(timer3_capture_irq_b), .timer3_count_in(timer3_count_in));
  pafs_periph i_per (.clk(clk), .srst(srst), .irq_a(timer3_capture_irq_a),
    .irq_b(timer3_capture_irq_b), .cnt_in(timer3_count_in), .mask_a(mask_a),
    .t3_out(timer3_out), .addr(ext_addr), .n_a(n_a), .n_b(n_b), .n_t(n_t));
  task close_out;
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails = fails + 1;
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tog(input integer k);
    p5_pin_in[k] <= 1'b1;
    repeat (8) @(posedge clk);
    p5_pin_in[k] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task t_regs;
    xfer(0, `PAFS_ADDR_P5_DIR, 0);
    chk("p5_dir", 32'h7, rv);
    xfer(0, 12'h0fc, 0);
    chk("bad_err", 1, {31'h0, er});
    chk("bad_data", 0, rv);
    xfer(1, `PAFS_ADDR_P7_LATCH, 32'hff);
    xfer(0, `PAFS_ADDR_P7_IN, 0);
    chk("p7_in", 32'h5a, rv);
    chk("p7_sel", 32'hff, {24'h0, p7_analog_sel});
  endtask
  task t_gpio;
    xfer(1, `PAFS_ADDR_AL_LATCH, 32'ha5c3);
    xfer(1, `PAFS_ADDR_AL_DIR, 32'h0f0f);
    repeat (2) @(posedge clk);
    #1 chk("al_out", 32'ha5c3, {16'h0, al_pin_out});
    chk("al_oe", 32'hf0f0, {16'h0, al_pin_oe});
  endtask
  task t_alt;
    xfer(1, `PAFS_ADDR_AL_MODE, 32'hffff);
    xfer(1, `PAFS_ADDR_AH_MODE, 32'h7f);
    xfer(1, `PAFS_ADDR_P5_DIR, 0);
    xfer(1, `PAFS_ADDR_P5_MODE, 32'h4);
    repeat (2) @(posedge clk);
    #1 pa = {9'h0, ext_addr};
    pt = timer3_out;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk);
      #1 chk("al_out", {16'h0, pa[15:0]}, {16'h0, al_pin_out});
      chk("ah_out", {25'h0, pa[22:16]}, {25'h0, ah_pin_out});
      chk("t3_pin", {31'h0, pt}, {31'h0, p5_pin_out[2]});
      chk("oe", 32'h7fffff, {ah_pin_oe, al_pin_oe});
      pa = {9'h0, ext_addr};
      pt = timer3_out;
    end
  endtask
  task t_edge;
    xfer(1, `PAFS_ADDR_EDGE_SEL, 32'h0d);
    xfer(1, `PAFS_ADDR_P5_MODE, 32'h7);
    tog(0);
    chk("cap_a", 1, {24'h0, n_a});
    chk("p5_oe_mode", 32'h4, {29'h0, p5_pin_oe});
    mask_a <= 1'b1;
    tog(0);
    chk("count", 1, {24'h0, n_t});
    tog(1);
    chk("cap_b", 2, {24'h0, n_b});
    mask_a <= 1'b0;
    xfer(1, `PAFS_ADDR_EDGE_SEL, 32'h0e);
    tog(0);
    chk("no_edge", 1, {24'h0, n_a});
    xfer(1, `PAFS_ADDR_EDGE_SEL, 32'h0d);
    xfer(1, `PAFS_ADDR_P5_MODE, 0);
    tog(0);
    tog(1);
    chk("off_a", 1, {24'h0, n_a});
    chk("off_b", 2, {24'h0, n_b});
    chk("p5_oe_port", 32'h7, {29'h0, p5_pin_oe});
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end
  initial begin
    {psel, penable, pwrite, mask_a} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    p5_pin_in = 3'h0;
    p7_pin_in = 8'h5a;
    fails = 0;
    checks = 0;
    cyc = 0;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_gpio;
    t_alt;
    t_edge;
    close_out;
  end
endmodule // pafs_top_tb
bind pafs_top pafs_checker i_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .p5_pin_in(p5_pin_in),
  .p5_pin_out(p5_pin_out), .p5_pin_oe(p5_pin_oe), .p7_analog_sel(p7_analog_sel),
  .al_pin_out(al_pin_out), .al_pin_oe(al_pin_oe), .ah_pin_out(ah_pin_out),
  .ah_pin_oe(ah_pin_oe), .timer3_out(timer3_out), .ext_addr(ext_addr),
  .timer3_capture_irq_a(timer3_capture_irq_a), .timer3_capture_irq_b(timer3_capture_irq_b),
  .timer3_count_in(timer3_count_in));
